// File: logic/bridge_interrupt_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_chan_cfg.svh"
// What this block does
// - four software sources set their pending bit and raise the routed output
// - software sources have no enable; setting always raises the interrupt
// - routed line held while software pending set; writing 1 clears it
// - interrupt activity never stalls the other channel's transactions
// - five pci status flags set the config-status pending bit and interrupt
// - master data parity flag never feeds the config-status interrupt
// - writing 1 to config-status pending clears it and drops its output
// - local acknowledge read launches pci iack; lanes from size and address
// - local address passes unchanged onto pci address during iack
// - acknowledge read is delayed: retry until data latched, then return it
// - writes to acknowledge register ignored; pci reads give zero, no cycle
// - interrupt pin field does not affect the pci interrupt output
// - interrupt line field read/write, resets to zero, holds any value
// - hardware-event interrupts need their enable; route picks the output
module bridge_interrupt_channel (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// software sources and routes (level set by software)
	input wire logic [3:0] soft_irq_source,
	input wire logic [3:0] soft_irq_route,
	// config-status interrupt control
	input wire logic cfg_status_irq_enable,
	input wire logic cfg_status_irq_route,
	// pci status flags
	input wire logic detected_parity_err,
	input wire logic signalled_sys_err,
	input wire logic rcvd_master_abort,
	input wire logic rcvd_target_abort,
	input wire logic signalled_target_abort,
	input wire logic master_data_parity_flag,
	// write-1-to-clear strobes, one cycle
	input wire logic [3:0] soft_irq_clear,
	input wire logic cfg_status_irq_clear,
	// local access to the acknowledge register
	input wire logic local_iack_read,
	input wire logic local_iack_write,
	input wire logic [1:0] local_xfer_size,
	input wire irq_chan_pkg::word_t local_addr,
	// pci access to the acknowledge register
	input wire logic pci_iack_read,
	input wire logic pci_iack_write,
	// pci master side of the iack cycle
	input wire logic pci_iack_done,
	input wire irq_chan_pkg::word_t pci_iack_data,
	// pin and line field writes
	input wire logic int_pin_write,
	input wire irq_chan_pkg::cfg_byte_t int_pin_wdata,
	input wire logic int_line_write,
	input wire irq_chan_pkg::cfg_byte_t int_line_wdata,
	// interrupt outputs, active low
	output logic local_irq_out_n,
	output logic pci_int_n,
	// pending status
	output logic [3:0] soft_irq_pending,
	output logic cfg_status_irq_pending,
	// local answer
	output logic local_retry,
	output logic local_ack,
	output irq_chan_pkg::word_t local_rdata,
	// pci read answer
	output logic pci_ack,
	output irq_chan_pkg::word_t pci_rdata,
	// pci iack cycle request
	output logic pci_iack_req,
	output logic [3:0] pci_iack_cmd,
	output irq_chan_pkg::word_t pci_iack_addr,
	output irq_chan_pkg::byte_en_t pci_iack_lanes,
	// config fields
	output irq_chan_pkg::cfg_byte_t int_pin,
	output irq_chan_pkg::cfg_byte_t int_line
);
	import irq_chan_pkg::*;

	ack_state_e ack_state;
	word_t int_ack_launch_reg;
	logic [4:0] prev_flags;
	logic cfg_event;
	byte_en_t next_lanes;
	irq_route_if rt ();

	// only rising edges of the status flags count as events
	logic [4:0] flags;
	assign flags = {detected_parity_err, signalled_sys_err, rcvd_master_abort,
		rcvd_target_abort, signalled_target_abort};
	assign cfg_event = cfg_status_irq_enable & |(flags & ~prev_flags);

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prev_flags <= 5'h00;
		end else if (clk_en) begin
			prev_flags <= flags;
		end
	end

	// software pending: set wins over clear, no enable gate
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			soft_irq_pending <= 4'h0;
		end else if (clk_en) begin
			soft_irq_pending <= soft_irq_source | (soft_irq_pending & ~soft_irq_clear);
		end
	end

	// a flag held high does not re-arm the bit; only a new enabled rising edge sets it again
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cfg_status_irq_pending <= 1'b0;
		end else if (clk_en) begin
			cfg_status_irq_pending <= cfg_event | (cfg_status_irq_pending & ~cfg_status_irq_clear);
		end
	end

	assign rt.pending = {cfg_status_irq_pending, soft_irq_pending};
	assign rt.route = {cfg_status_irq_route, soft_irq_route};
	irq_route_merge merge (.rt(rt.dst));

	// outputs registered; independent of every transfer path
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pci_int_n <= 1'b1;
			local_irq_out_n <= 1'b1;
		end else if (clk_en) begin
			pci_int_n <= ~rt.pci_req;
			local_irq_out_n <= ~rt.local_req;
		end
	end

	iack_bytes lanes (.size(local_xfer_size), .addr_lo(local_addr[1:0]), .lanes(next_lanes));

	// delayed acknowledge read: retry until pci data is latched
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ack_state <= ack_idle;
			int_ack_launch_reg <= 32'h0000_0000;
			pci_iack_req <= 1'b0;
			pci_iack_cmd <= `IACK_CMD;
			pci_iack_addr <= 32'h0000_0000;
			pci_iack_lanes <= 4'h0;
			local_retry <= 1'b0;
			local_ack <= 1'b0;
			local_rdata <= 32'h0000_0000;
		end else if (clk_en) begin
			local_retry <= 1'b0;
			local_ack <= 1'b0;
			unique case (ack_state)
				ack_idle: begin
					if (local_iack_read && !local_iack_write) begin
						ack_state <= ack_busy;
						pci_iack_req <= 1'b1;
						pci_iack_addr <= local_addr;
						pci_iack_lanes <= next_lanes;
						local_retry <= 1'b1;
					end
				end
				ack_busy: begin
					if (pci_iack_done) begin
						pci_iack_req <= 1'b0;
						int_ack_launch_reg <= pci_iack_data;
						ack_state <= ack_ready;
					end
					if (local_iack_read) begin
						local_retry <= 1'b1;
					end
				end
				ack_ready: begin
					if (local_iack_read) begin
						local_ack <= 1'b1;
						local_rdata <= int_ack_launch_reg;
						ack_state <= ack_idle;
					end
				end
			endcase
		end
	end

	// pci side reads zero and never starts a cycle
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pci_ack <= 1'b0;
			pci_rdata <= 32'h0000_0000;
		end else if (clk_en) begin
			pci_ack <= pci_iack_read | pci_iack_write;
			pci_rdata <= 32'h0000_0000;
		end
	end

	// config fields: plain storage
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			int_pin <= `INT_PIN_RESET;
			int_line <= `INT_LINE_RESET;
		end else if (clk_en) begin
			if (int_pin_write) begin
				int_pin <= int_pin_wdata;
			end
			if (int_line_write) begin
				int_line <= int_line_wdata;
			end
		end
	end
endmodule
`default_nettype wire

// File: logic/irq_chan_cfg.svh
`ifndef IRQ_CHAN_CFG_SVH
`define IRQ_CHAN_CFG_SVH

// number of software interrupt sources
`define SOFT_IRQ_COUNT 4
// reset value of the interrupt pin field: one interrupt implemented
`define INT_PIN_RESET 8'h01
// reset value of the interrupt line field
`define INT_LINE_RESET 8'h00
// bus command code driven during the acknowledge cycle
`define IACK_CMD 4'h0
// route bit value that selects the pci output
`define ROUTE_PCI 1'b1

`endif

// File: logic/irq_chan_pkg.sv
package irq_chan_pkg;
	typedef logic [3:0] byte_en_t;
	typedef logic [31:0] word_t;
	typedef logic [7:0] cfg_byte_t;
	typedef enum logic [1:0] {ack_idle, ack_busy, ack_ready} ack_state_e;
endpackage

// File: logic/irq_route_if.sv
`timescale 1ns/1ps
`default_nettype none
// pending and route bits travel together into the output merge
interface irq_route_if;
	logic [4:0] pending;
	logic [4:0] route;
	logic pci_req;
	logic local_req;
	modport src (output pending, output route, input pci_req, input local_req);
	modport dst (input pending, input route, output pci_req, output local_req);
endinterface
`default_nettype wire

// File: logic/irq_route_merge.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_chan_cfg.svh"
// splits the pending bits by route onto the two output requests
module irq_route_merge (
	irq_route_if.dst rt
);
	import irq_chan_pkg::*;
	// the pin field is deliberately not an input here
	assign rt.pci_req = |(rt.pending & rt.route);
	assign rt.local_req = |(rt.pending & ~rt.route);
endmodule
`default_nettype wire

// File: logic/iack_bytes.sv
`timescale 1ns/1ps
`default_nettype none
// turns local transfer size and address low bits into pci byte enables
module iack_bytes (
	// local request shape
	input wire logic [1:0] size,
	input wire logic [1:0] addr_lo,
	// active-high lane enables
	output logic [3:0] lanes
);
	import irq_chan_pkg::*;
	// size 0 = word, 1 = byte, 2 = half, 3 = three bytes
	function automatic byte_en_t lane_mask(input logic [1:0] s, input logic [1:0] a);
		byte_en_t base;
		base = 4'h0;
		unique case (s)
			2'h1: base = 4'h1;
			2'h2: base = 4'h3;
			2'h3: base = 4'h7;
			2'h0: base = 4'hf;
		endcase
		lane_mask = byte_en_t'(base << a);
	endfunction
	assign lanes = lane_mask(size, addr_lo);
endmodule
`default_nettype wire

// File: testbench/bic_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bic_asserts (
	// clock and controls
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [3:0] soft_irq_source,
	input wire logic [3:0] soft_irq_route,
	input wire logic cfg_status_irq_route,
	// requests
	input wire logic local_iack_read,
	input wire irq_chan_pkg::word_t local_addr,
	input wire logic pci_iack_read,
	input wire logic pci_iack_done,
	// watched outputs
	input wire logic local_irq_out_n,
	input wire logic pci_int_n,
	input wire logic [3:0] soft_irq_pending,
	input wire logic cfg_status_irq_pending,
	input wire logic local_retry,
	input wire logic pci_ack,
	input wire irq_chan_pkg::word_t pci_rdata,
	input wire logic pci_iack_req,
	input wire logic [3:0] pci_iack_cmd,
	input wire irq_chan_pkg::word_t pci_iack_addr
);
	// active-high request behind each output, from pending bits and routes
	wire logic loc_want = |(soft_irq_pending & ~soft_irq_route) | (cfg_status_irq_pending & !cfg_status_irq_route);
	wire logic pci_want = |(soft_irq_pending & soft_irq_route) | (cfg_status_irq_pending & cfg_status_irq_route);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_soft_set:
	assert property (clk_en && soft_irq_source != 0 |=> (soft_irq_pending & $past(soft_irq_source)) == $past(soft_irq_source)) else $error("soft set");
	a_local_out:
	assert property (clk_en |=> local_irq_out_n == !$past(loc_want)) else $error("local out");
	a_pci_out:
	assert property (clk_en |=> pci_int_n == !$past(pci_want)) else $error("pci out");
	a_iack_launch:
	assert property ($rose(pci_iack_req) |-> $past(local_iack_read) && pci_iack_addr == $past(local_addr) && pci_iack_cmd == 4'h0) else $error("launch");
	a_busy_retry:
	assert property (clk_en && local_iack_read && pci_iack_req && !pci_iack_done |=> local_retry) else $error("retry");
	a_req_hold:
	assert property (pci_iack_req && !pci_iack_done |=> pci_iack_req) else $error("req hold");
	a_req_drop:
	assert property ($fell(pci_iack_req) |-> $past(pci_iack_done)) else $error("req drop");
	a_pci_zero:
	assert property (clk_en && pci_iack_read |=> pci_ack && pci_rdata == '0) else $error("pci read");
endmodule
bind bridge_interrupt_channel bic_asserts bic_asserts_inst (.*);
`default_nettype wire

// File: testbench/pci_iack_target.sv
`timescale 1ns/1ps
`default_nettype none
module pci_iack_target #(parameter irq_chan_pkg::word_t vector = 32'h0000_005a) (
	// pci side
	input wire logic clk_sys,
	input wire logic pci_iack_req,
	input wire logic [3:0] wait_cycles,
	output logic pci_iack_done = 1'b0,
	output irq_chan_pkg::word_t pci_iack_data = '0
);
	logic [3:0] count = '0;
	// data valid only with done; otherwise it toggles, so stale values match the vector only every other cycle after a done
	always @(negedge clk_sys) begin
		pci_iack_done <= 1'b0;
		pci_iack_data <= ~pci_iack_data;
		count <= count + 4'h1;
		if (!pci_iack_req || pci_iack_done) count <= '0;
		else if (count == wait_cycles) begin
			pci_iack_done <= 1'b1;
			pci_iack_data <= vector;
		end
	end
endmodule
`default_nettype wire

// File: testbench/test_bridge_interrupt_channel.sv
`timescale 1ns/1ps
`default_nettype none
module test_bridge_interrupt_channel;
	import irq_chan_pkg::*;
	localparam word_t VEC = 32'h0000_005a;
	logic clk_sys = 0, reset_n = 0, clk_en = 1, master_data_parity_flag = 0;
	logic cfg_status_irq_enable = 0, cfg_status_irq_route = 0, cfg_status_irq_clear = 0;
	logic [3:0] soft_irq_source = 0, soft_irq_route = 4'h5, soft_irq_clear = 0, wait_cycles = 0;
	logic local_iack_read = 0, local_iack_write = 0, pci_iack_read = 0, pci_iack_write = 0;
	logic int_pin_write = 0, int_line_write = 0;
	logic [1:0] local_xfer_size = 0;
	logic [4:0] flags = 0;
	word_t local_addr = 0;
	cfg_byte_t int_pin_wdata = 0, int_line_wdata = 0;
	wire logic detected_parity_err, signalled_sys_err, rcvd_master_abort, rcvd_target_abort, signalled_target_abort;
	wire logic pci_iack_done, local_irq_out_n, pci_int_n, cfg_status_irq_pending, local_retry, local_ack, pci_ack, pci_iack_req;
	wire logic [3:0] soft_irq_pending, pci_iack_cmd, pci_iack_lanes;
	wire word_t pci_iack_data, local_rdata, pci_rdata, pci_iack_addr;
	wire cfg_byte_t int_pin, int_line;
	int err_count = 0, tests_run = 0;
	assign {detected_parity_err, signalled_sys_err, rcvd_master_abort, rcvd_target_abort, signalled_target_abort} = flags;
	always #25 clk_sys = ~clk_sys;
	bridge_interrupt_channel bridge_interrupt_channel_inst (.*);
	pci_iack_target #(.vector(VEC)) pci_iack_target_inst (.clk_sys, .pci_iack_req, .wait_cycles, .pci_iack_done, .pci_iack_data);
	task cyc(input int n); repeat (n) @(negedge clk_sys); endtask
	task chk(input word_t got, input word_t exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// the master keeps repeating the read until the latched vector returns
	task iack(input logic [1:0] sz, input word_t a, input logic [3:0] lanes, input logic [3:0] w);
		wait_cycles = w;
		local_xfer_size = sz;
		local_addr = a;
		local_iack_read = 1;
		cyc(1);
		local_iack_read = 0;
		chk(local_retry, 1);
		chk(pci_iack_lanes, lanes);
		chk(pci_iack_addr, a);
		repeat (20) if (local_ack !== 1'b1) begin
			cyc(1);
			local_iack_read = 1;
			cyc(1);
			local_iack_read = 0;
		end
		chk(local_ack, 1);
		chk(local_rdata, VEC);
	endtask
	// main sequence
	initial begin
		cyc(8);
		reset_n = 1;
		chk(int_pin, 8'h01);
		chk(int_line, 8'h00);
		int_line_wdata = 8'hff;
		int_line_write = 1;
		int_pin_write = 1;
		cyc(1);
		int_line_write = 0;
		int_pin_write = 0;
		chk({int_pin, int_line}, 16'h00ff);
		for (int i = 0; i < 4; i++) begin
			soft_irq_source[i] = 1;
			cyc(1);
			soft_irq_source[i] = 0;
			cyc(1);
			chk(soft_irq_pending, 4'h1 << i);
			chk({pci_int_n, local_irq_out_n}, i[0] ? 2'b10 : 2'b01);
			soft_irq_clear[i] = 1;
			cyc(1);
			soft_irq_clear[i] = 0;
			cyc(1);
			chk({soft_irq_pending, pci_int_n, local_irq_out_n}, 6'h03);
		end
		// five status flags in turn, then the excluded parity flag
		for (int k = 0; k < 6; k++) begin
			cfg_status_irq_enable = 1;
			cfg_status_irq_route = k[0];
			if (k < 5) flags = 5'h1 << k;
			else master_data_parity_flag = 1;
			cyc(1);
			flags = 0;
			master_data_parity_flag = 0;
			cyc(1);
			chk({cfg_status_irq_pending, pci_int_n, local_irq_out_n}, k == 5 ? 3'h3 : k[0] ? 3'h5 : 3'h6);
			cfg_status_irq_enable = 0;
			cfg_status_irq_clear = 1;
			cyc(1);
			cfg_status_irq_clear = 0;
			flags = 5'h1f;
			cyc(1);
			flags = 0;
			cyc(1);
			chk({cfg_status_irq_pending, pci_int_n, local_irq_out_n}, 3'h3);
		end
		local_iack_write = 1;
		pci_iack_write = 1;
		cyc(1);
		local_iack_write = 0;
		pci_iack_write = 0;
		pci_iack_read = 1;
		cyc(1);
		pci_iack_read = 0;
		chk({pci_ack, pci_iack_req, pci_rdata}, 34'h2_0000_0000);
		iack(2'd1, 32'h0000_1003, 4'b1000, 4'd0);
		iack(2'd2, 32'h0000_2002, 4'b1100, 4'd5);
		iack(2'd0, 32'h0000_3000, 4'hf, 4'd2);
		iack(2'd3, 32'h0000_4001, 4'b1110, 4'd1);
		stop_test();
	end
	// watchdog well beyond the roughly 80 cycles the sequence needs
	initial begin
		#1000000;
		err_count++;
		stop_test();
	end
endmodule
`default_nettype wire
